// ===== logic/wdt_core.sv
// Watchdog timer with sleep entry control and an Avalon-MM register slave.
//
// The address map and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/10ps
module wdt_core (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic config_watchdog_enable_i,
	input wire logic crystal_source_i,
	input wire logic osc_fail_i,
	input wire logic wake_event_i,
	input wire logic low_freq_ready_i,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic avs_response_err_o,
	output logic wdt_reset_o,
	output logic wdt_wake_o,
	output logic osc_driver_on_o,
	output logic io_freeze_o,
	output logic master_clear_pull_low_o,
	output logic asleep_o
);
	// ----------------------------------------------------------------
	// Registers and state
	// ----------------------------------------------------------------
	logic [7:0] ctrl_r;
	logic [7:0] presc_cfg_r;
	logic timeout_flag_r;
	logic pdown_flag_r;
	wdt_pkg::wdt_state_e state_r;
	logic [15:0] lf_div_r;
	logic lf_tick;
	logic [wdt_pkg::PRESC16_W-1:0] presc16_r;
	logic [wdt_pkg::PRESC8_W-1:0] presc8_r;
	logic [10:0] ost_cnt_r;
	logic bus_ack;
	logic clr_cmd;
	logic sleep_cmd;
	logic wdt_on;
	logic held;
	logic clear_cnt;
	logic p16_tap;
	logic p8_tap;
	logic timeout;
	logic bus_req;
	logic bus_rd_take;
	logic bus_wr;
	logic wake;
	logic p16_ovf;
	logic sleep_entry;
	logic sleep_level;
	logic ost_done;
	logic [3:0] period_tap;
	logic [15:0] period_mask;
	logic [7:0] presc8_last;
	logic [7:0] status_byte;
	logic [31:0] readdata_nxt;
	logic response_err_nxt;

	// ----------------------------------------------------------------
	// Helper functions
	// ----------------------------------------------------------------
	// Tap position on the 16-bit prescaler for a period code.
	function automatic logic [3:0] tap_index(input logic [3:0] code);
		if (code > wdt_pkg::PS_MAX_CODE) begin
			tap_index = 4'(wdt_pkg::PS_MAX_CODE + 4'(wdt_pkg::PS_BASE_LOG2 - 1));
		end else begin
			tap_index = 4'(code + 4'(wdt_pkg::PS_BASE_LOG2 - 1));
		end
	endfunction : tap_index

	// Mask of every prescaler bit below a tap position.
	function automatic logic [15:0] below_mask(input logic [3:0] tap);
		below_mask = 16'((17'h00001 << tap) - 17'h00001);
	endfunction : below_mask

	// Last count of the shared 8-bit stage for a ratio code, 1:2 up to 1:256.
	function automatic logic [7:0] ratio_last(input logic [2:0] ratio);
		ratio_last = 8'((9'h002 << ratio) - 9'h001);
	endfunction : ratio_last

	// Address match used by the command decode.
	function automatic logic is_addr(input logic [3:0] addr, input logic [3:0] target);
		is_addr = addr == target;
	endfunction : is_addr

	// ----------------------------------------------------------------
	// Bus slave
	// ----------------------------------------------------------------
	assign bus_req = avs_read | avs_write;
	assign bus_ack = ~avs_waitrequest;
	assign bus_rd_take = avs_read & avs_waitrequest;
	// Lane 0 carries every register, so a write without it is dropped.
	assign bus_wr = avs_write & bus_ack & avs_byteenable[0];

	// ----------------------------------------------------------------
	// Command decode
	// ----------------------------------------------------------------
	assign clr_cmd = bus_wr && is_addr(avs_address, wdt_pkg::ADDR_CMD) && avs_writedata[wdt_pkg::CMD_CLEAR_BIT];
	assign sleep_cmd = bus_wr && is_addr(avs_address, wdt_pkg::ADDR_CMD) && avs_writedata[wdt_pkg::CMD_SLEEP_BIT];

	// Waitrequest idles high and drops for exactly one cycle per request. It comes straight from a
	// flop, and the read data are loaded one edge before the master takes them.
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			avs_waitrequest <= 1'b1;
		end else begin
			avs_waitrequest <= ~(bus_req & avs_waitrequest);
		end
	end

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	always_comb begin
		status_byte = 8'h00;
		status_byte[wdt_pkg::ST_TIMEOUT_BIT] = timeout_flag_r;
		status_byte[wdt_pkg::ST_PDOWN_BIT] = pdown_flag_r;
		status_byte[wdt_pkg::ST_ASLEEP_BIT] = state_r != wdt_pkg::WDT_AWAKE;
		status_byte[wdt_pkg::ST_RUN_BIT] = wdt_on & ~held;
		// Reflects only the oscillator's own readiness, not the watchdog's request.
		status_byte[wdt_pkg::ST_LFSTABLE_BIT] = low_freq_ready_i;
		status_byte[wdt_pkg::ST_OSTRUN_BIT] = state_r == wdt_pkg::WDT_OSTWAIT;
	end

	always_comb begin
		readdata_nxt = 32'h0000_0000;
		response_err_nxt = 1'b0;
		case (avs_address)
			wdt_pkg::ADDR_WDT_CTRL: begin
				readdata_nxt[7:0] = ctrl_r & wdt_pkg::CTRL_WMASK;
			end
			wdt_pkg::ADDR_TMR_PRESC: begin
				readdata_nxt[7:0] = presc_cfg_r;
			end
			wdt_pkg::ADDR_STATUS: begin
				readdata_nxt[7:0] = status_byte;
			end
			wdt_pkg::ADDR_CMD: begin
				readdata_nxt = 32'h0000_0000;
			end
			default: begin
				response_err_nxt = 1'b1;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			avs_readdata <= 32'h0000_0000;
			avs_response_err_o <= 1'b0;
		end else if (bus_rd_take) begin
			avs_readdata <= readdata_nxt;
			avs_response_err_o <= response_err_nxt;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			ctrl_r <= wdt_pkg::CTRL_RESET;
		end else if (bus_wr && avs_address == wdt_pkg::ADDR_WDT_CTRL) begin
			ctrl_r <= avs_writedata[7:0] & wdt_pkg::CTRL_WMASK;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			presc_cfg_r <= wdt_pkg::PRESC_RESET;
		end else if (bus_wr && avs_address == wdt_pkg::ADDR_TMR_PRESC) begin
			presc_cfg_r <= avs_writedata[7:0];
		end
	end

	// ----------------------------------------------------------------
	// Low-frequency time base
	// ----------------------------------------------------------------
	// The system clock is fixed here, so a divider stands in for the 31 kHz source.
	assign lf_tick = lf_div_r == 16'(wdt_pkg::LF_DIV_CYCLES - 1);

	always_ff @(posedge clk_i) begin
		if (srst_i || lf_tick) begin
			lf_div_r <= 16'h0000;
		end else begin
			lf_div_r <= lf_div_r + 16'h0001;
		end
	end

	// ----------------------------------------------------------------
	// Enable, hold and clear
	// ----------------------------------------------------------------
	assign wdt_on = config_watchdog_enable_i | ctrl_r[wdt_pkg::CTRL_EN_BIT];
	assign held = state_r == wdt_pkg::WDT_OSTWAIT;
	assign wake = (state_r == wdt_pkg::WDT_ASLEEP) && (wake_event_i || timeout);
	assign sleep_entry = state_r == wdt_pkg::WDT_AWAKE && sleep_cmd;
	assign sleep_level = state_r == wdt_pkg::WDT_ASLEEP || sleep_entry;
	assign ost_done = ost_cnt_r == 11'(wdt_pkg::OST_TICKS);
	assign clear_cnt = ~wdt_on | clr_cmd | osc_fail_i | held | wake | (sleep_cmd & wdt_on);

	// ----------------------------------------------------------------
	// Prescaler chain
	// ----------------------------------------------------------------
	// The 16-bit stage counts whenever the watchdog runs; the shared 8-bit stage divides its tap further when assigned.
	assign period_tap = tap_index(ctrl_r[wdt_pkg::CTRL_PS_MSB:wdt_pkg::CTRL_PS_LSB]);
	assign period_mask = below_mask(period_tap);
	assign p16_tap = presc16_r[period_tap];
	// The period elapses when the tap bit and every bit below it are set on a low-frequency tick.
	assign p16_ovf = lf_tick & p16_tap & ((presc16_r & period_mask) == period_mask);
	assign presc8_last = ratio_last(presc_cfg_r[wdt_pkg::PRESC_RATIO_MSB:wdt_pkg::PRESC_RATIO_LSB]);
	assign p8_tap = presc8_r == presc8_last;
	// Spans 32 ticks (about 1 ms) up to 65536 x 256 ticks (about 541 s).
	assign timeout = wdt_on & ~held & p16_ovf
		& (~presc_cfg_r[wdt_pkg::PRESC_ASSIGN_BIT] | p8_tap);

	always_ff @(posedge clk_i) begin
		if (srst_i || clear_cnt) begin
			presc16_r <= '0;
		end else if (lf_tick) begin
			presc16_r <= presc16_r + 16'h0001;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i || clear_cnt || ~presc_cfg_r[wdt_pkg::PRESC_ASSIGN_BIT]) begin
			presc8_r <= '0;
		end else if (p16_ovf) begin
			presc8_r <= p8_tap ? 8'h00 : presc8_r + 8'h01;
		end
	end

	// ----------------------------------------------------------------
	// Sleep controller
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			state_r <= wdt_pkg::WDT_AWAKE;
			ost_cnt_r <= 11'h000;
		end else begin
			case (state_r)
				wdt_pkg::WDT_AWAKE: begin
					if (sleep_cmd) begin
						state_r <= wdt_pkg::WDT_ASLEEP;
					end
				end
				wdt_pkg::WDT_ASLEEP: begin
					if (wake && crystal_source_i) begin
						state_r <= wdt_pkg::WDT_OSTWAIT;
						ost_cnt_r <= 11'h000;
					end else if (wake) begin
						state_r <= wdt_pkg::WDT_AWAKE;
					end
				end
				wdt_pkg::WDT_OSTWAIT: begin
					if (lf_tick) begin
						ost_cnt_r <= ost_cnt_r + 11'h001;
					end
					if (ost_done) begin
						state_r <= wdt_pkg::WDT_AWAKE;
					end
				end
				default: state_r <= wdt_pkg::WDT_AWAKE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Status flags
	// ----------------------------------------------------------------
	// Sleep entry wins over a time-out in the same cycle, so the flag still shows that sleep began.
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			timeout_flag_r <= 1'b1;
		end else if (sleep_entry) begin
			timeout_flag_r <= 1'b1;
		end else if (wake && timeout) begin
			timeout_flag_r <= 1'b0;
		end else if (state_r == wdt_pkg::WDT_AWAKE && timeout) begin
			timeout_flag_r <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			pdown_flag_r <= 1'b1;
		end else if (sleep_entry) begin
			pdown_flag_r <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Core reloads its program counter with the reset vector on this pulse.
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			wdt_reset_o <= 1'b0;
		end else begin
			wdt_reset_o <= state_r == wdt_pkg::WDT_AWAKE && timeout;
		end
	end

	// Core continues at its next instruction on this pulse.
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			wdt_wake_o <= 1'b0;
		end else begin
			wdt_wake_o <= wake && timeout;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			osc_driver_on_o <= 1'b1;
		end else begin
			osc_driver_on_o <= ~sleep_level;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			io_freeze_o <= 1'b0;
		end else begin
			io_freeze_o <= sleep_level;
		end
	end

	// The time-out reset stays internal; the pin is never pulled.
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			master_clear_pull_low_o <= 1'b0;
		end else begin
			master_clear_pull_low_o <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			asleep_o <= 1'b0;
		end else begin
			asleep_o <= sleep_level;
		end
	end
endmodule : wdt_core

// ===== shared/wdt_pkg.sv
// Package with register map, field layout, reset values and timing constants for the watchdog block.
package wdt_pkg;
	// Register byte addresses on the Avalon-MM slave.
	localparam logic [3:0] ADDR_WDT_CTRL = 4'h0;
	localparam logic [3:0] ADDR_TMR_PRESC = 4'h4;
	localparam logic [3:0] ADDR_STATUS = 4'h8;
	localparam logic [3:0] ADDR_CMD = 4'hc;

	// Control register layout.
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_PS_LSB = 1;
	localparam int CTRL_PS_MSB = 4;
	localparam logic [7:0] CTRL_RESET = 8'h08;
	localparam logic [7:0] CTRL_WMASK = 8'h1f;
	localparam logic [3:0] PS_MAX_CODE = 4'hb;
	localparam int PS_BASE_LOG2 = 5;

	// Timer prescale configuration layout.
	localparam int PRESC_ASSIGN_BIT = 3;
	localparam int PRESC_RATIO_LSB = 0;
	localparam int PRESC_RATIO_MSB = 2;
	localparam logic [7:0] PRESC_RESET = 8'hff;

	// Status register layout.
	localparam int ST_TIMEOUT_BIT = 0;
	localparam int ST_PDOWN_BIT = 1;
	localparam int ST_ASLEEP_BIT = 2;
	localparam int ST_RUN_BIT = 3;
	localparam int ST_LFSTABLE_BIT = 4;
	localparam int ST_OSTRUN_BIT = 5;

	// Command register: writing a one to a bit issues the instruction.
	localparam int CMD_CLEAR_BIT = 0;
	localparam int CMD_SLEEP_BIT = 1;

	// Low-frequency tick derived from the 25 MHz clock.
	localparam int CLK_HZ = 25000000;
	localparam int LF_OSC_HZ = 31000;
	localparam int LF_DIV_CYCLES = CLK_HZ / LF_OSC_HZ;
	localparam int PRESC16_W = 16;
	localparam int PRESC8_W = 8;
	localparam int OST_TICKS = 1024;
	localparam logic [31:0] PC_RESET_VECTOR = 32'h0000_0000;

	// Sleep controller states.
	typedef enum logic [2:0] {
		WDT_AWAKE = 3'b001,
		WDT_ASLEEP = 3'b010,
		WDT_OSTWAIT = 3'b100
	} wdt_state_e;
endpackage : wdt_pkg

// ===== testbench/testbench.sv
// Self-checking bench for the watchdog block with sleep entry.
`timescale 1ns/10ps
module testbench;
	logic clk_i = 1'b0;
	logic srst_i = 1'b1;
	logic config_watchdog_enable_i, crystal_source_i, osc_fail_i, wake_event_i, low_freq_ready_i;
	logic [3:0] avs_address, avs_byteenable;
	logic avs_read, avs_write, avs_waitrequest, avs_response_err_o;
	logic [31:0] avs_writedata, avs_readdata;
	logic wdt_reset_o, wdt_wake_o, osc_driver_on_o, io_freeze_o, master_clear_pull_low_o, asleep_o;
	logic [32:0] exp_q[$];
	logic [32:0] msk_q[$];
	int miscompares = 0;
	int total_checks = 0;
	int seed = 30560;
	logic seen_r = 1'b0;
	wdt_cpu_model u_cpu (.clk_i(clk_i), .waitrequest_i(avs_waitrequest), .wdt_reset_i(wdt_reset_o),
		.wdt_wake_i(wdt_wake_o), .address_o(avs_address), .read_o(avs_read), .write_o(avs_write),
		.writedata_o(avs_writedata), .byteenable_o(avs_byteenable));
	wdt_core i_wdt_core (.*);
	initial begin
		forever #20 clk_i = ~clk_i;
	end
	task automatic chk(input string what, input logic [32:0] exp, input logic [32:0] got);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic conclude();
		if (miscompares == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : conclude
	task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] be = 4'hf);
		u_cpu.xfer(1'b1, a, d, be);
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [32:0] e, input logic [32:0] m);
		exp_q.push_back(e);
		msk_q.push_back(m);
		u_cpu.xfer(1'b0, a, 32'h0, 4'hf);
	endtask : rd
	task automatic run(input int n);
		repeat (n) begin
			@(posedge clk_i);
			if (wdt_reset_o || wdt_wake_o) seen_r = 1'b1;
		end
	endtask : run
	task automatic wait_pulse(input logic wake, output int n);
		n = 0;
		while ((wake ? wdt_wake_o : wdt_reset_o) !== 1'b1 && n < 40000) begin
			@(posedge clk_i);
			n++;
		end
	endtask : wait_pulse
	// Read data are judged against the oldest note at the edge that ends the access.
	always @(posedge clk_i) begin
		if (avs_read && !avs_waitrequest) begin
			chk("readback", exp_q[0] & msk_q[0], {avs_response_err_o, avs_readdata} & msk_q[0]);
			void'(exp_q.pop_front());
			void'(msk_q.pop_front());
		end
	end
	initial begin
		#3600000;
		miscompares++;
		conclude();
	end
	initial begin
		logic [31:0] v;
		int n;
		{config_watchdog_enable_i, crystal_source_i, osc_fail_i, wake_event_i} = 4'h0;
		low_freq_ready_i = 1'b1;
		repeat (2) @(posedge clk_i);
		srst_i <= 1'b0;
		rd(wdt_pkg::ADDR_WDT_CTRL, 33'h8, '1);
		rd(wdt_pkg::ADDR_STATUS, 33'h13, 33'h1_0000_001f);
		rd(wdt_pkg::ADDR_TMR_PRESC, 33'hff, '1);
		rd(4'h2, 33'h1_0000_0000, '1);
		wr(wdt_pkg::ADDR_WDT_CTRL, 32'hff, 4'he);
		rd(wdt_pkg::ADDR_WDT_CTRL, 33'h8, '1);
		for (int i = 0; i < 4; i++) begin
			v = $random(seed);
			wr(wdt_pkg::ADDR_WDT_CTRL, v);
			rd(wdt_pkg::ADDR_WDT_CTRL, {25'h0, v[7:0] & wdt_pkg::CTRL_WMASK}, '1);
		end
		wr(wdt_pkg::ADDR_TMR_PRESC, 32'h0);
		wr(wdt_pkg::ADDR_WDT_CTRL, 32'h0);
		rd(wdt_pkg::ADDR_STATUS, 33'h0, 33'h8);
		config_watchdog_enable_i <= 1'b1;
		rd(wdt_pkg::ADDR_STATUS, 33'h8, 33'h8);
		config_watchdog_enable_i <= 1'b0;
		wr(wdt_pkg::ADDR_WDT_CTRL, 32'h1);
		rd(wdt_pkg::ADDR_STATUS, 33'h8, 33'h8);
		run(15000);
		wr(wdt_pkg::ADDR_CMD, 32'h1);
		run(15000);
		osc_fail_i <= 1'b1;
		@(posedge clk_i);
		osc_fail_i <= 1'b0;
		chk("early pulse", 33'h0, {32'h0, seen_r});
		wait_pulse(1'b0, n);
		chk("awake time-out", 33'h1, {32'h0, n >= 24986 && n <= 26700});
		@(posedge clk_i);
		chk("pc after reset", 33'h0, {1'b0, u_cpu.pc_r});
		rd(wdt_pkg::ADDR_STATUS, 33'h2, 33'h3);
		wr(wdt_pkg::ADDR_CMD, 32'h2);
		run(2);
		chk("asleep", 33'h1, {32'h0, asleep_o});
		rd(wdt_pkg::ADDR_STATUS, 33'h1, 33'h3);
		wake_event_i <= 1'b1;
		run(3);
		wake_event_i <= 1'b0;
		chk("awake", 33'h0, {32'h0, asleep_o});
		wr(wdt_pkg::ADDR_CMD, 32'h2);
		wait_pulse(1'b1, n);
		chk("sleep time-out", 33'h1, {32'h0, n >= 24986 && n <= 26700});
		@(posedge clk_i);
		chk("pc after wake", 33'h1, {1'b0, u_cpu.pc_r});
		run(4);
		rd(wdt_pkg::ADDR_STATUS, 33'h0, 33'h7);
		low_freq_ready_i <= 1'b0;
		rd(wdt_pkg::ADDR_STATUS, 33'h08, 33'h18);
		crystal_source_i <= 1'b1;
		wr(wdt_pkg::ADDR_CMD, 32'h2);
		wake_event_i <= 1'b1;
		run(3);
		wake_event_i <= 1'b0;
		chk("start-up wait", 33'h0, {32'h0, asleep_o});
		rd(wdt_pkg::ADDR_STATUS, 33'h24, 33'h2c);
		srst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		srst_i <= 1'b0;
		crystal_source_i <= 1'b0;
		low_freq_ready_i <= 1'b1;
		rd(wdt_pkg::ADDR_WDT_CTRL, 33'h8, '1);
		rd(wdt_pkg::ADDR_STATUS, 33'h13, 33'h3f);
		conclude();
	end
endmodule : testbench
bind wdt_core wdt_checker i_wdt_checker (.*);

// ===== testbench/wdt_checker.sv
// Port-level assertions for the watchdog block.
`timescale 1ns/10ps
module wdt_checker (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic crystal_source_i,
	input wire logic osc_fail_i,
	input wire logic wake_event_i,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic wdt_reset_o,
	input wire logic wdt_wake_o,
	input wire logic osc_driver_on_o,
	input wire logic io_freeze_o,
	input wire logic master_clear_pull_low_o,
	input wire logic asleep_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);
	localparam int MIN_TO = 24986;
	logic [16:0] since_clr_r;
	logic cmd_acc;
	// The count restarts on the command, oscillator-fail, wake and pulse clears, but not while the watchdog is off or held, so it can overstate the real one.
	assign cmd_acc = avs_write && !avs_waitrequest && avs_byteenable[0] && avs_address == wdt_pkg::ADDR_CMD;
	always_ff @(posedge clk_i) begin
		if (srst_i || (cmd_acc && |avs_writedata[1:0]) || osc_fail_i || wake_event_i || wdt_reset_o || wdt_wake_o) begin
			since_clr_r <= 17'h0;
		end else if (!since_clr_r[16]) begin
			since_clr_r <= since_clr_r + 17'h1;
		end
	end
	sequence s_ctrl_rd;
		avs_read && !avs_waitrequest && avs_address == wdt_pkg::ADDR_WDT_CTRL;
	endsequence
	sequence s_sleep_cmd;
		cmd_acc && avs_writedata[1] && !asleep_o;
	endsequence
	AST_MASTER_CLEAR_PIN_IDLE: assert property (master_clear_pull_low_o == 1'b0) else $error("master clear pulled low");
	AST_CTRL_UPPER: assert property (s_ctrl_rd |-> avs_readdata[31:5] == 27'h0) else $error("upper bits set");
	AST_SLEEP_PINS: assert property (asleep_o |-> !osc_driver_on_o && io_freeze_o) else $error("pins not held");
	AST_SLEEP_ENTRY: assert property (s_sleep_cmd |-> ##[1:3] asleep_o) else $error("sleep not entered");
	AST_AWAKE_RESET: assert property (wdt_reset_o |-> !$past(asleep_o) && !$past(wdt_reset_o))
		else $error("bad reset pulse");
	AST_SLEEP_WAKE: assert property (wdt_wake_o |-> $past(asleep_o)) else $error("wake while awake");
	AST_TO_MIN: assert property (wdt_reset_o || wdt_wake_o |-> since_clr_r >= MIN_TO) else $error("early time-out");
	AST_WAKE_EXIT: assert property (wdt_wake_o && !crystal_source_i |-> ##[0:3] !asleep_o)
		else $error("no wake");
endmodule : wdt_checker

// ===== testbench/wdt_cpu_model.sv
// Processor-core model: register bus master that follows watchdog resets and wakes.
`timescale 1ns/10ps
module wdt_cpu_model (
	input wire logic clk_i,
	input wire logic waitrequest_i,
	input wire logic wdt_reset_i,
	input wire logic wdt_wake_i,
	output logic [3:0] address_o,
	output logic read_o,
	output logic write_o,
	output logic [31:0] writedata_o,
	output logic [3:0] byteenable_o
);
	logic [31:0] pc_r = 32'h40;
	logic master_clear_pin_level_r = 1'b1;
	initial begin
		{address_o, read_o, write_o, writedata_o, byteenable_o} = '0;
	end
	always @(posedge clk_i) begin
		if (wdt_reset_i) begin
			pc_r <= 32'h0;
		end else if (wdt_wake_i) begin
			pc_r <= pc_r + 32'h1;
		end
	end
	task automatic xfer(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
		@(posedge clk_i);
		read_o <= !wr;
		write_o <= wr;
		address_o <= a;
		writedata_o <= d;
		byteenable_o <= be;
		do begin
			@(posedge clk_i);
		end while (waitrequest_i);
		read_o <= 1'b0;
		write_o <= 1'b0;
	endtask : xfer
endmodule : wdt_cpu_model
